// File: inc/ecs_pkg.sv
// package: register map, codes and carriers for the configuration error status bank
package ecs_pkg;

  // register numbers as seen by the fieldbus client
  localparam logic [15:0] ECS_ADDR_MODULE_COUNT = 16'h3acb;
  localparam logic [15:0] ECS_ADDR_CFG_ENABLED  = 16'h3acc;
  localparam logic [15:0] ECS_ADDR_RSVD_FIRST   = 16'h3acd;
  localparam logic [15:0] ECS_ADDR_RSVD_LAST    = 16'h3ad3;
  localparam logic [15:0] ECS_ADDR_ERR_COUNT    = 16'h3ad4;
  localparam logic [15:0] ECS_ADDR_SLOT_FIRST   = 16'h3ad5;
  localparam logic [15:0] ECS_ADDR_SLOT_LAST    = 16'h3ae8;
  localparam logic [15:0] ECS_ADDR_TAIL_LAST    = 16'h3afb;

  // error slots and their contents
  localparam int          ECS_MAX_ERRORS    = 10;
  localparam logic [15:0] ECS_CODE_NONE     = 16'hffff;
  localparam logic [15:0] ECS_LOC_RESET     = 16'h0000;
  localparam logic [15:0] ECS_DATA_ZERO     = 16'h0000;
  localparam logic [15:0] ECS_CODE_RSVD_A   = 16'h0000;
  localparam logic [15:0] ECS_CODE_RSVD_B   = 16'h0005;
  localparam logic [15:0] ECS_CODE_LO_FIRST = 16'h0001;
  localparam logic [15:0] ECS_CODE_LO_LAST  = 16'h0015;
  localparam logic [15:0] ECS_CODE_HI_FIRST = 16'h0064;
  localparam logic [15:0] ECS_CODE_HI_LAST  = 16'h0066;
  localparam logic [3:0]  ECS_CNT_RESET     = 4'h0;
  localparam logic [15:0] ECS_STATUS_RESET  = 16'h0000;

  // location word: module index 15:12, module error 9, input 8, channel 4:0
  typedef struct packed {
    logic [3:0] module_idx;
    logic [1:0] rsvd_hi;
    logic       module_err;
    logic       dir_in;
    logic [2:0] rsvd_lo;
    logic [4:0] chan_idx;
  } ecs_loc_t;

  // one detected error as reported by the configuration checker
  typedef struct packed {
    logic [15:0] code;
    ecs_loc_t    loc;
  } ecs_err_t;

  // register read request
  typedef struct packed {
    logic        en;
    logic [15:0] addr;
  } ecs_rd_req_t;

endpackage

// File: hdl/ecs_slot_mem.sv
// small memory holding the recorded error slots, registered read data
`timescale 1ns/1ps
module ecs_slot_mem #(
  parameter int DEPTH = 10,
  parameter int AW    = 4
) (
  input  wire logic            sys_clk,
  input  wire logic            wr_en,
  input  wire logic [AW-1:0]   wr_addr,
  input  wire ecs_pkg::ecs_err_t wr_data,
  input  wire logic [AW-1:0]   rd_addr,
  output ecs_pkg::ecs_err_t    rd_data
);
  import ecs_pkg::*;

  ecs_err_t mem [DEPTH];
  ecs_err_t rd_data_q;

  // write port; out-of-range addresses are dropped
  always_ff @(posedge sys_clk) begin
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // no reset on the array: empty slots are masked by the count upstream
  always_ff @(posedge sys_clk) begin
    if (int'(rd_addr) < DEPTH) begin
      rd_data_q <= mem[rd_addr];
    end else begin
      rd_data_q <= '0;
    end
  end

  assign rd_data = rd_data_q;

endmodule

// File: hdl/ecs_status_bank.sv
// read-only status bank for expansion module configuration errors
// Summary of operation
// - module count register reads the number of connected expansion modules
// - feature register reads 1 when command configuration enabled, else 0
// - reserved registers between feature and error count read zero, read-only
// - error count caps at ten; eleventh and later errors are ignored
// - codes 0 and 5 are reserved and never reported
// - codes 1, 2, 3: bad analog channel type, minimum, maximum
// - code 4: analog minimum greater than analog maximum
// - codes 6 and 8: bad analog filter and analog fallback value
// - codes 7 and 9: bad sampling setting and bad analog scope
// - codes 10, 11, 12: bad thermistor resistance, temperature, beta
// - code 13: bad digital functional mode value
// - codes 14, 15, 16: bad digital filter, fallback mode, fallback value
// - empty error-code slots read 65535
// - codes 100 and 101: bad first-module setting, module not configurable
// - each code pairs with a location word: channel, direction, kind, module
`timescale 1ns/1ps
module ecs_status_bank #(
  parameter int MAX_ERRORS = ecs_pkg::ECS_MAX_ERRORS
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic [15:0]          module_count,
  input  wire logic                 cfg_enabled,
  input  wire logic                 err_clear,
  input  wire logic                 err_valid,
  input  wire ecs_pkg::ecs_err_t    err_in,
  input  wire ecs_pkg::ecs_rd_req_t rd_req,
  output logic                      rd_valid,
  output logic [15:0]               rd_data
);
  import ecs_pkg::*;

  logic [3:0]  err_count_q;
  logic [3:0]  err_count_d;
  logic [3:0]  base_count;
  logic        code_ok;
  logic        accept;
  logic [15:0] slot_off;
  logic [3:0]  rd_slot;
  ecs_err_t    slot_rd;
  logic        p1_valid_q;
  logic [15:0] p1_addr_q;
  logic [15:0] p1_modcnt_q;
  logic        p1_enabled_q;
  logic [3:0]  p1_count_q;
  logic [15:0] p1_off;
  logic [15:0] rd_data_d;
  logic [15:0] rd_data_q;
  logic        rd_valid_q;

  // only codes 1 to 21 other than 5, and 100 to 102, get in; reserved encodings are refused here
  always_comb begin
    code_ok = ((err_in.code >= ECS_CODE_LO_FIRST) && (err_in.code <= ECS_CODE_LO_LAST))
           || ((err_in.code >= ECS_CODE_HI_FIRST) && (err_in.code <= ECS_CODE_HI_LAST));
    if (err_in.code == ECS_CODE_RSVD_B) begin
      code_ok = 1'b0;
    end
  end

  // a clear in the same cycle as an error lets the error land in slot 0
  assign base_count = err_clear ? ECS_CNT_RESET : err_count_q;
  assign accept     = err_valid && code_ok && (int'(base_count) < MAX_ERRORS);

  always_comb begin
    err_count_d = base_count;
    if (accept) begin
      err_count_d = base_count + 4'h1;
    end
  end

  // error count, saturating at the slot depth
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_count_q <= ECS_CNT_RESET;
    end else begin
      err_count_q <= err_count_d;
    end
  end

  // slot index of a read inside the code/location area
  assign slot_off = rd_req.addr - ECS_ADDR_SLOT_FIRST;
  assign rd_slot  = slot_off[4:1];

  // next free slot takes the error with its location word
  ecs_slot_mem #(
    .DEPTH (MAX_ERRORS),
    .AW    (4)
  ) u_slots (
    .sys_clk (sys_clk),
    .wr_en   (accept),
    .wr_addr (base_count),
    .wr_data (err_in),
    .rd_addr (rd_slot),
    .rd_data (slot_rd)
  );

  // first read stage: capture address and a snapshot of the live status
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      p1_valid_q   <= 1'b0;
      p1_addr_q    <= ECS_STATUS_RESET;
      p1_modcnt_q  <= ECS_STATUS_RESET;
      p1_enabled_q <= 1'b0;
      p1_count_q   <= ECS_CNT_RESET;
    end else begin
      p1_valid_q   <= rd_req.en;
      p1_addr_q    <= rd_req.addr;
      p1_modcnt_q  <= module_count;
      p1_enabled_q <= cfg_enabled;
      p1_count_q   <= err_count_q;
    end
  end

  assign p1_off = p1_addr_q - ECS_ADDR_SLOT_FIRST;

  // read mux; anything not named here, reserved included, reads zero
  always_comb begin
    rd_data_d = ECS_DATA_ZERO;
    if (p1_addr_q == ECS_ADDR_MODULE_COUNT) begin
      rd_data_d = p1_modcnt_q;
    end else if (p1_addr_q == ECS_ADDR_CFG_ENABLED) begin
      rd_data_d = {15'h0000, p1_enabled_q};
    end else if (p1_addr_q == ECS_ADDR_ERR_COUNT) begin
      rd_data_d = {12'h000, p1_count_q};
    end else if ((p1_addr_q >= ECS_ADDR_SLOT_FIRST) && (p1_addr_q <= ECS_ADDR_SLOT_LAST)) begin
      if (p1_off[4:1] >= p1_count_q) begin
        rd_data_d = p1_off[0] ? ECS_LOC_RESET : ECS_CODE_NONE;
      end else begin
        rd_data_d = p1_off[0] ? 16'(slot_rd.loc) : slot_rd.code;
      end
    end
  end

  // answer stage; writes do not exist, so the bank cannot be altered from outside
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= ECS_DATA_ZERO;
    end else begin
      rd_valid_q <= p1_valid_q;
      rd_data_q  <= p1_valid_q ? rd_data_d : ECS_DATA_ZERO;
    end
  end

  assign rd_valid = rd_valid_q;
  assign rd_data  = rd_data_q;

  // ---- checks ----
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_count_cap_max : assert property (int'(err_count_q) <= MAX_ERRORS)
    else $error("error count above ten");

  a_count_full_hold : assert property (
    (int'(err_count_q) == MAX_ERRORS) && !err_clear && err_valid
    |=> int'(err_count_q) == MAX_ERRORS)
    else $error("eleventh error was counted");

  a_count_step_one : assert property (
    err_valid && code_ok && !err_clear && (int'(err_count_q) < MAX_ERRORS)
    |=> err_count_q == $past(err_count_q) + 4'h1)
    else $error("accepted error did not advance count by one");

  a_rsvd_code_drop : assert property (
    err_valid && !err_clear
    && ((err_in.code == ECS_CODE_RSVD_A) || (err_in.code == ECS_CODE_RSVD_B))
    |=> $stable(err_count_q))
    else $error("reserved code was recorded");

  a_read_latency_two : assert property (rd_req.en |-> ##2 rd_valid)
    else $error("read answer not two cycles after request");

  a_modcount_read : assert property (
    rd_req.en && (rd_req.addr == ECS_ADDR_MODULE_COUNT)
    |-> ##2 rd_data == $past(module_count, 2))
    else $error("module count read wrong");

  a_feature_read : assert property (
    rd_req.en && (rd_req.addr == ECS_ADDR_CFG_ENABLED)
    |-> ##2 rd_data == {15'h0000, $past(cfg_enabled, 2)})
    else $error("feature register read wrong");

  a_rsvd_reads_zero : assert property (
    rd_req.en && (rd_req.addr >= ECS_ADDR_RSVD_FIRST) && (rd_req.addr <= ECS_ADDR_RSVD_LAST)
    |-> ##2 rd_data == ECS_DATA_ZERO)
    else $error("reserved register not zero");

  a_empty_slot_default : assert property (
    p1_valid_q && (p1_addr_q == ECS_ADDR_SLOT_FIRST) && (p1_count_q == ECS_CNT_RESET)
    |=> rd_data == ECS_CODE_NONE)
    else $error("empty slot did not read 65535");

  a_code_never_rsvd : assert property (
    p1_valid_q && (p1_addr_q >= ECS_ADDR_SLOT_FIRST) && (p1_addr_q <= ECS_ADDR_SLOT_LAST)
    && !p1_off[0]
    |=> (rd_data != ECS_CODE_RSVD_A) && (rd_data != ECS_CODE_RSVD_B))
    else $error("reserved code read back");

  // a clear with an error in the same cycle keeps the error, in slot 0
  a_clear_err_lands : assert property (
    err_clear && err_valid && code_ok
    |=> err_count_q == 4'h1)
    else $error("error with clear did not land in slot zero");

  a_clear_empties : assert property (
    err_clear && !err_valid
    |=> err_count_q == ECS_CNT_RESET)
    else $error("clear did not empty the bank");

  // count is read as it stood in the request cycle
  a_count_read : assert property (
    rd_req.en && (rd_req.addr == ECS_ADDR_ERR_COUNT)
    |-> ##2 rd_data == {12'h000, $past(err_count_q, 2)})
    else $error("error count read wrong");

  // location word of an empty slot must not leak stale memory contents
  a_empty_loc_zero : assert property (
    p1_valid_q && (p1_addr_q == ECS_ADDR_SLOT_FIRST + 16'h0001)
    && (p1_count_q == ECS_CNT_RESET)
    |=> rd_data == ECS_LOC_RESET)
    else $error("empty location word not zero");

  c_error_recorded : cover property (err_valid && code_ok ##1 err_count_q != ECS_CNT_RESET);
  c_count_saturated : cover property (int'(err_count_q) == MAX_ERRORS && err_valid);
  c_slot_read : cover property (rd_req.en && (rd_req.addr == ECS_ADDR_SLOT_FIRST) ##2 rd_valid);
  c_clear_with_error : cover property (err_clear && err_valid && code_ok);

endmodule

// File: verif/ecs_client_model.sv
// fieldbus register client model: issues reads to the status bank
`timescale 1ns/1ps
module ecs_client_model (
  input  wire logic        sys_clk,
  output ecs_pkg::ecs_rd_req_t rd_req,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data
);
  import ecs_pkg::*;

  initial rd_req = '0;

  // one read; the address is inverted once released so stale values cannot pass
  task automatic read(input logic [15:0] addr, output logic [15:0] data);
    int   n;
    logic got;
    n    = 0;
    got  = 1'b0;
    data = 16'hdead;
    @(posedge sys_clk);
    rd_req <= '{en: 1'b1, addr: addr};
    @(posedge sys_clk);
    rd_req <= '{en: 1'b0, addr: ~addr};
    // answer stands one cycle, so look just after each edge, bounded wait
    while (n < 5 && !got) begin
      @(posedge sys_clk);
      #1;
      if (rd_valid === 1'b1) begin
        data = rd_data;
        got  = 1'b1;
      end
      n++;
    end
  endtask
endmodule

// File: verif/expansion_config_error_status_tb_top.sv
// self-checking bench for the expansion configuration error status bank
`timescale 1ns/1ps
module expansion_config_error_status_tb_top;
  import ecs_pkg::*;
  logic        sys_clk, rst, cfg_enabled, err_clear, err_valid, rd_valid;
  logic [15:0] module_count, rd_data;
  ecs_err_t    err_in;
  ecs_rd_req_t rd_req;
  int          fails = 0, check_count = 0, cyc = 0;
  // code posted, then slot 0 code expected; refused codes leave the slot empty
  logic [31:0] rows [19] = '{32'h0000ffff, 32'h00010001, 32'h00020002, 32'h00030003,
    32'h00040004, 32'h0005ffff, 32'h00060006, 32'h00070007, 32'h00080008, 32'h00090009,
    32'h000a000a, 32'h000b000b, 32'h000c000c, 32'h000d000d, 32'h000e000e, 32'h000f000f,
    32'h00100010, 32'h00640064, 32'h00650065};

  ecs_status_bank i_ecs_status_bank (.sys_clk(sys_clk), .rst(rst),
    .module_count(module_count), .cfg_enabled(cfg_enabled), .err_clear(err_clear),
    .err_valid(err_valid), .err_in(err_in), .rd_req(rd_req), .rd_valid(rd_valid),
    .rd_data(rd_data));
  ecs_client_model i_ecs_client_model (.sys_clk(sys_clk), .rd_req(rd_req),
    .rd_valid(rd_valid), .rd_data(rd_data));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // hang guard, well above the roughly 300 cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t ns: read 0x%h expected 0x%h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp);
    logic [15:0] v;
    i_ecs_client_model.read(addr, v);
    cmp(v, exp);
  endtask

  // one error pulse, optionally with a clear in the same cycle
  task automatic post(input logic [15:0] code, input logic [15:0] loc, input logic clr);
    @(posedge sys_clk);
    err_valid <= 1'b1;
    err_clear <= clr;
    err_in    <= {code, loc};
    @(posedge sys_clk);
    err_valid <= 1'b0;
    err_clear <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst          = 1'b1;
    module_count = 16'h0003;
    cfg_enabled  = 1'b0;
    err_clear    = 1'b0;
    err_valid    = 1'b0;
    err_in       = '0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    // empty bank after reset
    rd_chk(ECS_ADDR_ERR_COUNT, 16'h0000);
    rd_chk(ECS_ADDR_SLOT_FIRST, ECS_CODE_NONE);
    // codes 0 to 16, 100 and 101 each alone, clear in the same cycle so it lands in slot 0
    foreach (rows[i]) begin
      post(rows[i][31:16], 16'h3102, 1'b1);
      rd_chk(ECS_ADDR_SLOT_FIRST, rows[i][15:0]);
      rd_chk(ECS_ADDR_ERR_COUNT, {15'h0, rows[i][15:0] != ECS_CODE_NONE});
    end
    // status follows its inputs; reserved block stays zero
    @(posedge sys_clk);
    module_count <= 16'h000d;
    cfg_enabled  <= 1'b1;
    rd_chk(ECS_ADDR_MODULE_COUNT, 16'h000d);
    rd_chk(ECS_ADDR_CFG_ENABLED, 16'h0001);
    @(posedge sys_clk);
    cfg_enabled <= 1'b0;
    rd_chk(ECS_ADDR_CFG_ENABLED, 16'h0000);
    for (logic [15:0] a = ECS_ADDR_RSVD_FIRST; a <= ECS_ADDR_RSVD_LAST; a++) begin
      rd_chk(a, 16'h0000);
    end
    // twelve errors back to back; only the first ten land, in order
    @(posedge sys_clk);
    err_clear <= 1'b1;
    @(posedge sys_clk);
    err_clear <= 1'b0;
    for (int k = 0; k < 12; k++) begin
      err_valid <= 1'b1;
      err_in    <= {16'(k + 1 + (k >= 4)), 4'(k), 12'h11f};
      @(posedge sys_clk);
    end
    err_valid <= 1'b0;
    rd_chk(ECS_ADDR_ERR_COUNT, 16'h000a);
    for (int k = 0; k < 10; k++) begin
      rd_chk(16'(ECS_ADDR_SLOT_FIRST + 2 * k), 16'(k + 1 + (k >= 4)));
      rd_chk(16'(ECS_ADDR_SLOT_FIRST + 2 * k + 1), {4'(k), 12'h11f});
    end
    rd_chk(16'(ECS_ADDR_SLOT_LAST + 1), 16'h0000);
    // a second reset empties the bank
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(ECS_ADDR_ERR_COUNT, 16'h0000);
    rd_chk(ECS_ADDR_SLOT_FIRST, ECS_CODE_NONE);
    rd_chk(16'(ECS_ADDR_SLOT_FIRST + 1), ECS_LOC_RESET);
    // reserved codes without a clear are dropped; a module error keeps its location
    post(ECS_CODE_RSVD_B, 16'h7200, 1'b0);
    post(ECS_CODE_RSVD_A, 16'h7200, 1'b0);
    rd_chk(ECS_ADDR_ERR_COUNT, 16'h0000);
    post(16'h0065, 16'h7200, 1'b0);
    rd_chk(ECS_ADDR_SLOT_FIRST, 16'h0065);
    rd_chk(16'(ECS_ADDR_SLOT_FIRST + 1), 16'h7200);
    rd_chk(ECS_ADDR_ERR_COUNT, 16'h0001);
    results();
  end
endmodule
